// *** rtl/lpb_pkg.sv ***
/*
 Shared constants, command and state types for the inter-bank command tracker.
 Assumes a 200 MHz system clock; delays are stored in ps and turned into cycles here.
*/
package lpb_pkg;

   localparam int NUM_BANKS = 4;
   localparam int CLK_PERIOD_PS = 5000;

   // Least times round up to whole cycles
   localparam int PRECHARGE_DELAY_PS = 18000;
   localparam int ACTIVATE_TO_COLUMN_DELAY_PS = 18000;
   localparam int ACTIVATE_TO_ACTIVATE_DELAY_PS = 10000;
   localparam int POWERDOWN_EXIT_DELAY_PS = 7500;
   localparam int SELF_REFRESH_EXIT_DELAY_PS = 100000;
   localparam int REFRESH_DELAY_PS = 90000;
   // Longest time rounds down
   localparam int AUTO_INIT_MAX_PS = 10000000;

   typedef logic [11:0] lpb_cnt_t;

   localparam lpb_cnt_t RP_CK =
      lpb_cnt_t'((PRECHARGE_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam lpb_cnt_t RCD_CK =
      lpb_cnt_t'((ACTIVATE_TO_COLUMN_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam lpb_cnt_t RRD_CK =
      lpb_cnt_t'((ACTIVATE_TO_ACTIVATE_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam lpb_cnt_t PDX_CK =
      lpb_cnt_t'((POWERDOWN_EXIT_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam lpb_cnt_t SRX_CK =
      lpb_cnt_t'((SELF_REFRESH_EXIT_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam lpb_cnt_t REF_CK =
      lpb_cnt_t'((REFRESH_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam lpb_cnt_t INIT_CK = lpb_cnt_t'(AUTO_INIT_MAX_PS / CLK_PERIOD_PS);
   localparam lpb_cnt_t MRR_CK = 12'h002;
   localparam lpb_cnt_t MRW_CK = 12'h005;
   localparam lpb_cnt_t BURST_CK = 12'h004;

   localparam logic [7:0] MR_RESET_ADDR = 8'h3F;

   typedef enum logic [3:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_BST, CMD_MRR, CMD_MRW, CMD_REF
   } lpb_cmd_e;

   typedef enum logic [2:0] {
      BANK_IDLE, BANK_ACTIVATING, BANK_ACTIVE, BANK_READING, BANK_WRITING,
      BANK_RD_AP, BANK_WR_AP, BANK_PRECHARGING
   } lpb_bank_e;

   typedef enum logic [2:0] {
      BOP_NONE, BOP_ACT, BOP_RD, BOP_WR, BOP_PRE, BOP_STOP
   } lpb_bop_e;

   typedef enum logic [2:0] {
      MODE_POWER_ON, MODE_RESETTING, MODE_NORMAL, MODE_MRR_IDLE,
      MODE_MRR_ACTIVE, MODE_MRR_RESET, MODE_MRW, MODE_REFRESH
   } lpb_mode_e;

   typedef struct packed {
      lpb_cmd_e   op;
      logic [1:0] bank;
      logic       all_banks;
      logic       auto_precharge;
      logic [7:0] mr_addr;
   } lpb_cmd_s;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  write_data_mask;
   } lpb_beat_s;

endpackage : lpb_pkg

// *** rtl/lpb_bank.sv ***
/*
 One bank's state with its own delay timer.
 Assumes the caller only sends operations that are legal for this bank.
*/
`timescale 1ns/1ps
module lpb_bank (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire lpb_pkg::lpb_bop_e op,
   input  wire logic             auto_precharge,
   output lpb_pkg::lpb_bank_e    state
);

   lpb_pkg::lpb_bank_e next_state;
   lpb_pkg::lpb_cnt_t  cnt;
   lpb_pkg::lpb_cnt_t  next_cnt;

   always_comb begin
      next_state = state;
      next_cnt = (cnt != 12'h000) ? cnt - 12'h001 : cnt;
      unique case (op)
         lpb_pkg::BOP_ACT: begin
            next_state = lpb_pkg::BANK_ACTIVATING;
            next_cnt = lpb_pkg::RCD_CK;
         end
         lpb_pkg::BOP_RD: begin
            next_state = auto_precharge ? lpb_pkg::BANK_RD_AP : lpb_pkg::BANK_READING; // RULE_04
            next_cnt = lpb_pkg::BURST_CK;
         end
         lpb_pkg::BOP_WR: begin
            next_state = auto_precharge ? lpb_pkg::BANK_WR_AP : lpb_pkg::BANK_WRITING; // RULE_04
            next_cnt = lpb_pkg::BURST_CK;
         end
         lpb_pkg::BOP_PRE: begin
            next_state = lpb_pkg::BANK_PRECHARGING; // RULE_04
            next_cnt = lpb_pkg::RP_CK;
         end
         lpb_pkg::BOP_STOP: begin
            // Cut bursts with auto precharge still close their row
            if (state == lpb_pkg::BANK_RD_AP || state == lpb_pkg::BANK_WR_AP) begin
               next_state = lpb_pkg::BANK_PRECHARGING;
               next_cnt = lpb_pkg::RP_CK;
            end else begin
               next_state = lpb_pkg::BANK_ACTIVE; // RULE_07
               next_cnt = 12'h000;
            end
         end
         lpb_pkg::BOP_NONE: begin
            if (cnt == 12'h001) begin // RULE_21
               unique case (state)
                  lpb_pkg::BANK_ACTIVATING,
                  lpb_pkg::BANK_READING,
                  lpb_pkg::BANK_WRITING:    next_state = lpb_pkg::BANK_ACTIVE;
                  lpb_pkg::BANK_RD_AP,
                  lpb_pkg::BANK_WR_AP: begin
                     next_state = lpb_pkg::BANK_PRECHARGING;
                     next_cnt = lpb_pkg::RP_CK;
                  end
                  lpb_pkg::BANK_PRECHARGING: next_state = lpb_pkg::BANK_IDLE;
                  lpb_pkg::BANK_IDLE,
                  lpb_pkg::BANK_ACTIVE:      next_state = state;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= lpb_pkg::BANK_IDLE;
         cnt <= 12'h000;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_act_to_active: assert property ( // RULE_21
      (op == lpb_pkg::BOP_ACT) ##1 (op == lpb_pkg::BOP_NONE)[*4]
      |=> state == lpb_pkg::BANK_ACTIVE)
      else $error("bank not active after activate delay");
   a_pre_to_idle: assert property ( // RULE_21
      (op == lpb_pkg::BOP_PRE) ##1 (op == lpb_pkg::BOP_NONE)[*3]
      |=> state == lpb_pkg::BANK_PRECHARGING ##1 state == lpb_pkg::BANK_IDLE)
      else $error("bank not idle exactly after precharge delay");
   a_burst_enter: assert property ( // RULE_04
      (op == lpb_pkg::BOP_RD) && !auto_precharge |=> state == lpb_pkg::BANK_READING)
      else $error("read did not enter reading");

endmodule : lpb_bank

// *** rtl/lpb_wmask.sv ***
/*
 Write data path with per-byte mask.
 Assumes one beat per cycle, sampled with the command clock.
*/
`timescale 1ns/1ps
module lpb_wmask (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              beat_valid,
   input  wire lpb_pkg::lpb_beat_s beat,
   input  wire logic              accept,
   output logic [3:0]             byte_we,
   output logic [31:0]            wdata
);

   logic [3:0]  next_we;
   logic [31:0] next_wdata;

   for (genvar i = 0; i < 4; i++) begin : g_byte
      always_comb begin
         // A high mask bit makes the lane don't-care
         next_we[i] = beat_valid && accept && !beat.write_data_mask[i]; // RULE_18
         next_wdata[8*i +: 8] = next_we[i] ? beat.data[8*i +: 8] : wdata[8*i +: 8];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         byte_we <= 4'h0;
         wdata <= 32'h00000000;
      end else begin
         byte_we <= next_we;
         wdata <= next_wdata;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_mask_inhibit: assert property ( // RULE_18
      beat_valid && accept |=> byte_we == ~$past(beat.write_data_mask))
      else $error("byte enables do not follow the mask");

endmodule : lpb_wmask

// *** rtl/lpb_tracker.sv ***
/*
 Command tracker for a four-bank memory: bank states, device modes,
 legality of each command and the masked write data path.
 Assumes commands arrive already decoded, one per cycle, synchronous to sys_clk.
*/
`timescale 1ns/1ps

// What this block does
// RULE_01 - A NOP leaves every bank's state and operation untouched.
// RULE_02 - With bank n idle, bank m takes whatever its own state allows.
// RULE_03 - ACTIVATE opens bank m; activates are spaced by the activate delay.
// RULE_04 - READ/WRITE start a burst state; PRECHARGE enters Precharging.
// RULE_05 - A WRITE during a read burst needs burst end or terminate first.
// RULE_06 - A READ during a write burst needs burst end or terminate first.
// RULE_07 - Burst terminate only during a burst; the bank returns to Active.
// RULE_08 - Burst terminate must target the bank that holds the burst.
// RULE_09 - Refresh and mode-register write only with every bank idle.
// RULE_10 - Mode-register read allowed beside activating, precharging or active banks.
// RULE_11 - Only NOPs during a mode read; then back to idle or active.
// RULE_12 - Only NOPs during a mode write; then all banks idle.
// RULE_13 - Banks bursting with auto precharge should receive only NOPs; the code also accepts a burst terminate to them.
// RULE_14 - Other banks take valid commands during an auto precharge burst.
// RULE_15 - Reset from power-on starts auto-initialisation, all banks idle.
// RULE_16 - Reset is a mode-register write to a reserved address.
// RULE_17 - While resetting, a mode read enters resetting mode reading.
// RULE_18 - A low mask bit writes its byte; high inhibits it.
// RULE_19 - Commands act only with clock enable high twice and exit delay over.
// RULE_20 - Unlisted state and command pairs are illegal.
// RULE_21 - Idle after precharge delay; active after activate-to-column delay.
// RULE_22 - Precharge closes one bank or all, whatever the others do.
// RULE_23 - Any command not allowed by current states raises an error flag.
module lpb_tracker (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              cke,
   input  wire logic              sr_exit,
   input  wire lpb_pkg::lpb_cmd_s cmd,
   input  wire logic              wr_beat_valid,
   input  wire lpb_pkg::lpb_beat_s wr_beat,
   output lpb_pkg::lpb_bank_e     bank_state [lpb_pkg::NUM_BANKS],
   output lpb_pkg::lpb_mode_e     dev_mode,
   output logic                   cmd_illegal,
   output logic [3:0]             mem_byte_we,
   output logic [31:0]            mem_wdata
);

   // Clock enable history and exit delay
   logic              cke_prev;
   lpb_pkg::lpb_cnt_t exit_cnt;
   lpb_pkg::lpb_cnt_t next_exit_cnt;
   logic              cmd_live;

   always_comb begin
      next_exit_cnt = (exit_cnt != 12'h000) ? exit_cnt - 12'h001 : exit_cnt;
      if (cke && !cke_prev) begin
         next_exit_cnt = sr_exit ? lpb_pkg::SRX_CK : lpb_pkg::PDX_CK;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cke_prev <= 1'b0;
         exit_cnt <= 12'h000;
      end else begin
         cke_prev <= cke;
         exit_cnt <= next_exit_cnt;
      end
   end

   // Both edges high and no exit delay pending
   assign cmd_live = cke && cke_prev && (exit_cnt == 12'h000); // RULE_19

   // Summary of bank states
   logic       all_idle;
   logic       any_reading;
   logic       any_writing;
   logic       burst_any;
   logic [1:0] burst_bank;

   always_comb begin
      all_idle = 1'b1;
      any_reading = 1'b0;
      any_writing = 1'b0;
      burst_bank = 2'h0;
      for (int b = 0; b < lpb_pkg::NUM_BANKS; b++) begin
         if (bank_state[b] != lpb_pkg::BANK_IDLE) begin
            all_idle = 1'b0;
         end
         if (bank_state[b] == lpb_pkg::BANK_READING || bank_state[b] == lpb_pkg::BANK_RD_AP) begin
            any_reading = 1'b1;
            burst_bank = 2'(b);
         end
         if (bank_state[b] == lpb_pkg::BANK_WRITING || bank_state[b] == lpb_pkg::BANK_WR_AP) begin
            any_writing = 1'b1;
            burst_bank = 2'(b);
         end
      end
      burst_any = any_reading || any_writing;
   end

   // Command legality and dispatch
   lpb_pkg::lpb_bank_e tgt;
   lpb_pkg::lpb_bop_e  bop [lpb_pkg::NUM_BANKS];
   lpb_pkg::lpb_mode_e next_mode;
   lpb_pkg::lpb_cnt_t  mode_cnt;
   lpb_pkg::lpb_cnt_t  next_mode_cnt;
   lpb_pkg::lpb_cnt_t  rrd_cnt;
   lpb_pkg::lpb_cnt_t  next_rrd_cnt;
   logic               ok;
   logic               tgt_open;
   logic               tgt_pre_ok;
   logic               all_pre_ok;
   logic               next_illegal;

   always_comb begin
      tgt = bank_state[cmd.bank];
      tgt_open = (tgt == lpb_pkg::BANK_ACTIVE) || (tgt == lpb_pkg::BANK_READING)
                 || (tgt == lpb_pkg::BANK_WRITING);
      tgt_pre_ok = (tgt == lpb_pkg::BANK_IDLE) || (tgt == lpb_pkg::BANK_ACTIVE)
                   || (tgt == lpb_pkg::BANK_PRECHARGING);
      all_pre_ok = 1'b1;
      for (int b = 0; b < lpb_pkg::NUM_BANKS; b++) begin
         if (bank_state[b] != lpb_pkg::BANK_IDLE && bank_state[b] != lpb_pkg::BANK_ACTIVE
             && bank_state[b] != lpb_pkg::BANK_PRECHARGING) begin
            all_pre_ok = 1'b0;
         end
      end
   end

   always_comb begin
      ok = 1'b1;
      for (int b = 0; b < lpb_pkg::NUM_BANKS; b++) begin
         bop[b] = lpb_pkg::BOP_NONE; // RULE_01
      end
      next_mode = dev_mode;
      next_mode_cnt = (mode_cnt != 12'h000) ? mode_cnt - 12'h001 : mode_cnt;
      next_rrd_cnt = (rrd_cnt != 12'h000) ? rrd_cnt - 12'h001 : rrd_cnt;

      // Timed modes end by themselves
      if (mode_cnt == 12'h001) begin
         unique case (dev_mode)
            lpb_pkg::MODE_RESETTING,
            lpb_pkg::MODE_MRR_IDLE,
            lpb_pkg::MODE_MRR_RESET,
            lpb_pkg::MODE_MRR_ACTIVE,
            lpb_pkg::MODE_MRW,
            lpb_pkg::MODE_REFRESH:   next_mode = lpb_pkg::MODE_NORMAL; // RULE_11 RULE_12
            lpb_pkg::MODE_POWER_ON,
            lpb_pkg::MODE_NORMAL:    next_mode = dev_mode;
         endcase
      end

      if (cmd_live && cmd.op != lpb_pkg::CMD_NOP) begin
         unique case (dev_mode)
            lpb_pkg::MODE_POWER_ON: begin
               ok = (cmd.op == lpb_pkg::CMD_MRW) && (cmd.mr_addr == lpb_pkg::MR_RESET_ADDR); // RULE_15 RULE_16
               if (ok) begin
                  next_mode = lpb_pkg::MODE_RESETTING;
                  next_mode_cnt = lpb_pkg::INIT_CK;
               end
            end
            lpb_pkg::MODE_RESETTING: begin
               ok = (cmd.op == lpb_pkg::CMD_MRR); // RULE_17
               if (ok) begin
                  next_mode = lpb_pkg::MODE_MRR_RESET;
                  next_mode_cnt = lpb_pkg::MRR_CK;
               end
            end
            lpb_pkg::MODE_NORMAL: begin
               unique case (cmd.op)
                  lpb_pkg::CMD_ACT: begin
                     // A count of one left means the spacing is already met
                     ok = (tgt == lpb_pkg::BANK_IDLE) && (rrd_cnt <= 12'h001); // RULE_03
                     if (ok) begin
                        bop[cmd.bank] = lpb_pkg::BOP_ACT;
                        next_rrd_cnt = lpb_pkg::RRD_CK;
                     end
                  end
                  lpb_pkg::CMD_RD,
                  lpb_pkg::CMD_WR: begin
                     // Opposite-direction burst must be over or terminated first
                     ok = tgt_open && ((cmd.op == lpb_pkg::CMD_RD) ? !any_writing
                                                                    : !any_reading); // RULE_05 RULE_06
                     if (ok) begin
                        // A new burst elsewhere cuts the running one
                        if (burst_any && burst_bank != cmd.bank) begin
                           bop[burst_bank] = lpb_pkg::BOP_STOP; // RULE_14
                        end
                        bop[cmd.bank] = (cmd.op == lpb_pkg::CMD_RD) ? lpb_pkg::BOP_RD
                                                                     : lpb_pkg::BOP_WR; // RULE_04
                     end
                  end
                  lpb_pkg::CMD_PRE: begin
                     ok = cmd.all_banks ? all_pre_ok : tgt_pre_ok; // RULE_22
                     if (ok) begin
                        for (int b = 0; b < lpb_pkg::NUM_BANKS; b++) begin
                           if (cmd.all_banks || cmd.bank == 2'(b)) begin
                              bop[b] = lpb_pkg::BOP_PRE; // RULE_22
                           end
                        end
                     end
                  end
                  lpb_pkg::CMD_BST: begin
                     ok = burst_any && (cmd.bank == burst_bank); // RULE_07 RULE_08
                     if (ok) begin
                        bop[cmd.bank] = lpb_pkg::BOP_STOP;
                     end
                  end
                  lpb_pkg::CMD_MRR: begin
                     ok = !burst_any && (tgt_pre_ok || tgt == lpb_pkg::BANK_ACTIVATING); // RULE_10
                     if (ok) begin
                        next_mode = (tgt == lpb_pkg::BANK_ACTIVE) ? lpb_pkg::MODE_MRR_ACTIVE
                                                                  : lpb_pkg::MODE_MRR_IDLE;
                        next_mode_cnt = lpb_pkg::MRR_CK;
                     end
                  end
                  lpb_pkg::CMD_MRW: begin
                     ok = all_idle; // RULE_09
                     if (ok) begin
                        next_mode = (cmd.mr_addr == lpb_pkg::MR_RESET_ADDR)
                                    ? lpb_pkg::MODE_RESETTING : lpb_pkg::MODE_MRW; // RULE_16
                        next_mode_cnt = (cmd.mr_addr == lpb_pkg::MR_RESET_ADDR)
                                        ? lpb_pkg::INIT_CK : lpb_pkg::MRW_CK;
                     end
                  end
                  lpb_pkg::CMD_REF: begin
                     ok = all_idle; // RULE_09
                     if (ok) begin
                        next_mode = lpb_pkg::MODE_REFRESH;
                        next_mode_cnt = lpb_pkg::REF_CK;
                     end
                  end
                  lpb_pkg::CMD_NOP: ok = 1'b1;
                  default: ok = 1'b0; // RULE_20
               endcase
            end
            // Timed windows accept NOPs only
            lpb_pkg::MODE_MRR_IDLE,
            lpb_pkg::MODE_MRR_ACTIVE,
            lpb_pkg::MODE_MRR_RESET,
            lpb_pkg::MODE_MRW,
            lpb_pkg::MODE_REFRESH:    ok = 1'b0; // RULE_11 RULE_12
         endcase
      end

      // Non-NOP during the exit delay is also a violation
      next_illegal = (cmd.op != lpb_pkg::CMD_NOP) && cke && cke_prev
                     && ((exit_cnt != 12'h000) || !ok); // RULE_23
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_mode <= lpb_pkg::MODE_POWER_ON;
         mode_cnt <= 12'h000;
         rrd_cnt <= 12'h000;
         cmd_illegal <= 1'b0;
      end else begin
         dev_mode <= next_mode;
         mode_cnt <= next_mode_cnt;
         rrd_cnt <= next_rrd_cnt;
         cmd_illegal <= next_illegal;
      end
   end

   for (genvar b = 0; b < lpb_pkg::NUM_BANKS; b++) begin : g_bank
      lpb_bank u_bank (
         .sys_clk        (sys_clk),
         .rst_n          (rst_n),
         .op             (bop[b]),
         .auto_precharge (cmd.auto_precharge),
         .state          (bank_state[b])
      );
   end

   // Beats land only while a write burst runs
   lpb_wmask u_wmask (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .beat_valid (wr_beat_valid),
      .beat       (wr_beat),
      .accept     (any_writing),
      .byte_we    (mem_byte_we),
      .wdata      (mem_wdata)
   );

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_nop_holds: assert property ( // RULE_01
      cmd.op == lpb_pkg::CMD_NOP && bank_state[0] == lpb_pkg::BANK_ACTIVE
      |=> bank_state[0] == lpb_pkg::BANK_ACTIVE)
      else $error("nop changed an active bank");

   a_bst_ends: assert property ( // RULE_07
      cmd_live && dev_mode == lpb_pkg::MODE_NORMAL && cmd.op == lpb_pkg::CMD_BST
      && bank_state[cmd.bank] == lpb_pkg::BANK_READING
      |=> bank_state[$past(cmd.bank)] == lpb_pkg::BANK_ACTIVE)
      else $error("burst terminate did not return bank to active");

   a_mrr_active: assert property ( // RULE_10
      cmd_live && dev_mode == lpb_pkg::MODE_NORMAL && cmd.op == lpb_pkg::CMD_MRR
      && tgt == lpb_pkg::BANK_ACTIVE && !burst_any
      |=> (dev_mode == lpb_pkg::MODE_MRR_ACTIVE)[*2] ##1 dev_mode == lpb_pkg::MODE_NORMAL)
      else $error("mode read window wrong");

   a_mrr_reset: assert property ( // RULE_17
      cmd_live && dev_mode == lpb_pkg::MODE_RESETTING && cmd.op == lpb_pkg::CMD_MRR
      |=> dev_mode == lpb_pkg::MODE_MRR_RESET)
      else $error("resetting mode read not entered");

   a_reset_mrw: assert property ( // RULE_15 RULE_16
      cmd_live && dev_mode == lpb_pkg::MODE_POWER_ON && cmd.op == lpb_pkg::CMD_MRW
      && cmd.mr_addr == lpb_pkg::MR_RESET_ADDR |=> dev_mode == lpb_pkg::MODE_RESETTING)
      else $error("reset write did not start initialisation");

   a_window_flag: assert property ( // RULE_23
      cmd_live && dev_mode == lpb_pkg::MODE_MRW && cmd.op != lpb_pkg::CMD_NOP
      |=> cmd_illegal)
      else $error("command in mode write window not flagged");

   a_cke_gate: assert property ( // RULE_19
      !(cke && cke_prev) && cmd.op == lpb_pkg::CMD_ACT
      && bank_state[cmd.bank] == lpb_pkg::BANK_IDLE
      |=> bank_state[$past(cmd.bank)] == lpb_pkg::BANK_IDLE)
      else $error("command acted with clock enable low");

   a_rd_blocked: assert property ( // RULE_06
      cmd_live && cmd.op == lpb_pkg::CMD_RD && any_writing
      |=> cmd_illegal && !$past(any_reading))
      else $error("read during write burst not refused");

   c_reset_path: cover property (
      dev_mode == lpb_pkg::MODE_RESETTING ##1 dev_mode == lpb_pkg::MODE_MRR_RESET);
   c_bst: cover property (
      cmd_live && cmd.op == lpb_pkg::CMD_BST && !next_illegal);
   c_pre_all: cover property (
      cmd_live && cmd.op == lpb_pkg::CMD_PRE && cmd.all_banks && !next_illegal);
   c_mrr_active: cover property (dev_mode == lpb_pkg::MODE_MRR_ACTIVE);

endmodule : lpb_tracker

// *** bench/lpb_ctl_model.sv ***
/*
 Controller model: drives one command or one write beat at a time.
 Assumes a single bench process calls its tasks.
*/
`timescale 1ns/1ps
module lpb_ctl_model (
   input  wire logic          sys_clk,
   output lpb_pkg::lpb_cmd_s  cmd,
   output logic               beat_valid,
   output lpb_pkg::lpb_beat_s beat
);
   initial begin
      cmd = '0;
      beat_valid = 1'b0;
      beat = '0;
   end
   // Command then NOP; callers space commands and wait out windows
   task automatic issue(input lpb_pkg::lpb_cmd_e op, input logic [1:0] bk,
                        input logic ap, input logic [7:0] ad);
      @(posedge sys_clk) cmd <= '{op, bk, 1'b0, ap, ad};
      @(posedge sys_clk) cmd.op <= lpb_pkg::CMD_NOP;
   endtask : issue
   task automatic put(input logic [31:0] d, input logic [3:0] m);
      @(posedge sys_clk) beat_valid <= 1'b1;
      beat <= '{d, m};
      // Released data lines must not keep the last value
      @(posedge sys_clk) beat_valid <= 1'b0;
      beat.data <= ~d;
   endtask : put
endmodule : lpb_ctl_model

// *** bench/lpb_tracker_tb.sv ***
/*
 Self-checking bench for the command tracker.
 Assumes the controller model in lpb_ctl_model drives the command port.
*/
`timescale 1ns/1ps
module lpb_tracker_tb;
   logic               sys_clk = 1'b0;
   logic               rst_n = 1'b0;
   logic               cke = 1'b1;
   logic               sr_exit = 1'b0;
   logic               bv, ill;
   logic [3:0]         we;
   logic [31:0]        wd;
   lpb_pkg::lpb_cmd_s  cmd;
   lpb_pkg::lpb_beat_s beat;
   lpb_pkg::lpb_bank_e bs [lpb_pkg::NUM_BANKS];
   lpb_pkg::lpb_mode_e mode;
   int                 mismatches = 0;
   int                 cmp_count = 0;
   always #2.5 sys_clk = ~sys_clk;
   lpb_tracker lpb_tracker_inst (.sys_clk, .rst_n, .cke, .sr_exit, .cmd, .wr_beat_valid(bv),
      .wr_beat(beat), .bank_state(bs), .dev_mode(mode), .cmd_illegal(ill),
      .mem_byte_we(we), .mem_wdata(wd));
   lpb_ctl_model lpb_ctl_model_inst (.sys_clk, .cmd, .beat_valid(bv), .beat);
   task automatic results;
      if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic bk(input int i, input lpb_pkg::lpb_bank_e e);
      chk(32'(bs[i]), 32'(e));
   endtask : bk
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   // Returns just after the edge that takes the command
   task automatic go(input lpb_pkg::lpb_cmd_e op, input logic [1:0] b = 2'h0,
                     input logic ap = 1'b0, input logic [7:0] a = 8'h00);
      lpb_ctl_model_inst.issue(op, b, ap, a);
      #1;
   endtask : go
   task automatic t_power;
      go(lpb_pkg::CMD_ACT);
      chk(32'(ill), 32'h1);
      go(lpb_pkg::CMD_MRW, 2'h0, 1'b0, 8'h3F);
      chk(32'(mode), 32'(lpb_pkg::MODE_RESETTING));
      go(lpb_pkg::CMD_MRR);
      chk(32'(mode), 32'(lpb_pkg::MODE_MRR_RESET));
      tick(int'(lpb_pkg::INIT_CK) + 20);
      chk(32'(mode), 32'(lpb_pkg::MODE_NORMAL));
   endtask : t_power
   task automatic t_act;
      go(lpb_pkg::CMD_ACT, 2'h0);
      bk(0, lpb_pkg::BANK_ACTIVATING);
      go(lpb_pkg::CMD_ACT, 2'h1);
      chk(32'(ill), 32'h0);
      tick(3);
      bk(0, lpb_pkg::BANK_ACTIVE);
   endtask : t_act
   task automatic t_burst;
      go(lpb_pkg::CMD_RD, 2'h0);
      bk(0, lpb_pkg::BANK_READING);
      go(lpb_pkg::CMD_BST, 2'h0);
      bk(0, lpb_pkg::BANK_ACTIVE);
      go(lpb_pkg::CMD_RD, 2'h0);
      go(lpb_pkg::CMD_WR, 2'h1);
      chk(32'(ill), 32'h1);
      go(lpb_pkg::CMD_BST, 2'h1);
      chk(32'(ill), 32'h1);
      go(lpb_pkg::CMD_WR, 2'h1);
      go(lpb_pkg::CMD_RD, 2'h0);
      chk(32'(ill), 32'h1);
      go(lpb_pkg::CMD_BST, 2'h1);
      bk(1, lpb_pkg::BANK_ACTIVE);
      go(lpb_pkg::CMD_BST, 2'h1);
      chk(32'(ill), 32'h1);
   endtask : t_burst
   task automatic t_mask;
      go(lpb_pkg::CMD_WR, 2'h1, 1'b1);
      bk(1, lpb_pkg::BANK_WR_AP);
      lpb_ctl_model_inst.put(32'hA1B2C3D4, 4'h2);
      #1;
      chk(32'(we), 32'hD);
      chk(wd, 32'hA1B200D4);
      // Other bank precharged while bank 1 ends its auto precharge burst
      go(lpb_pkg::CMD_PRE, 2'h0);
      bk(0, lpb_pkg::BANK_PRECHARGING);
      bk(1, lpb_pkg::BANK_PRECHARGING);
      tick(4);
      bk(1, lpb_pkg::BANK_IDLE);
      bk(0, lpb_pkg::BANK_IDLE);
      lpb_ctl_model_inst.put(32'h5A5A5A5A, 4'h0);
      #1;
      chk(32'(we), 32'h0);
      chk(wd, 32'hA1B200D4);
   endtask : t_mask
   task automatic t_mode;
      go(lpb_pkg::CMD_ACT, 2'h2);
      tick(3);
      go(lpb_pkg::CMD_MRR, 2'h2);
      chk(32'(ill), 32'h0);
      chk(32'(mode), 32'(lpb_pkg::MODE_MRR_ACTIVE));
      tick(2);
      chk(32'(mode), 32'(lpb_pkg::MODE_NORMAL));
      go(lpb_pkg::CMD_MRW, 2'h0, 1'b0, 8'h01);
      chk(32'(ill), 32'h1);
      go(lpb_pkg::CMD_PRE, 2'h2);
      tick(4);
      go(lpb_pkg::CMD_MRW, 2'h0, 1'b0, 8'h01);
      chk(32'(mode), 32'(lpb_pkg::MODE_MRW));
      go(lpb_pkg::CMD_ACT, 2'h3);
      chk(32'(ill), 32'h1);
      tick(3);
      chk(32'(mode), 32'(lpb_pkg::MODE_NORMAL));
   endtask : t_mode
   task automatic t_cke;
      @(posedge sys_clk) cke <= 1'b0;
      go(lpb_pkg::CMD_ACT, 2'h3);
      bk(3, lpb_pkg::BANK_IDLE);
      chk(32'(ill), 32'h0);
      bk(0, lpb_pkg::BANK_IDLE);
   endtask : t_cke
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      tick(25);
      t_power();
      t_act();
      t_burst();
      t_mask();
      t_mode();
      t_cke();
      results();
   end
   // Run needs about 2120 cycles
   initial begin
      #20000;
      mismatches++;
      results();
   end
endmodule : lpb_tracker_tb
